// file: common/status_lamp_defs.vh
// Constants for the status lamp pattern generator
`ifndef STATUS_LAMP_DEFS_VH
`define STATUS_LAMP_DEFS_VH

// Clock and millisecond tick
`define CLK_PERIOD_PS        32'h0000_1388
`define TICK_PERIOD_PS       32'h3B9A_CA00
`define TICK_CYCLES          (`TICK_PERIOD_PS / `CLK_PERIOD_PS)

// Lamp colour codes
`define COL_OFF              3'h0
`define COL_WHITE            3'h1
`define COL_GREEN            3'h2
`define COL_BLUE             3'h3
`define COL_YELLOW           3'h4
`define COL_ORANGE           3'h5
`define COL_RED              3'h6

// Lamp display modes
`define MODE_VALVE           3'h0
`define MODE_VALVE_ERR       3'h1
`define MODE_VALVE_ERR_WARN  3'h2
`define MODE_STATUS_CAT      3'h3
`define MODE_FIXED           3'h4

// Position blink patterns
`define BLINK_STEADY         2'h0
`define BLINK_SLOW           2'h1
`define BLINK_FAST           2'h2

// Phase timings in milliseconds
`define MS_FAST_ON           16'h007D
`define MS_SLOW_ON           16'h00FA
`define MS_FAST_OFF_END      16'h0177
`define MS_SHORT             16'h0032
`define MS_LONG_ON           16'h01C2
`define MS_BASE_PERIOD       16'h01F4
`define MS_ALT_HALF          16'h03E8
`define MS_MAINT_ON          16'h03E8
`define MS_MAINT_PERIOD      16'h0FA0
`define MS_LOCATE            16'h2710
`define MS_PULSE             16'h0019
`define MS_PULSE_GAP         16'h0064
`define MS_TEACH_FLASH       16'h0064
`define MS_TEACH_TOTAL       16'h0258

// Reset values
`define RST_MS               16'h0000
`define RST_COLOUR           3'h0

`endif

// file: design/status_lamp_pattern_generator.v
// Status lamp colour and blink pattern generator
`timescale 1ns/10ps
`include "status_lamp_defs.vh"
//
// Contract
// [RL1] Errors show in error colour; always red in status-category mode.
// [RL2] Internal, bus, teach faults and invalid sensor signals count as errors.
// [RL3] Orange warning for service mode, manual control or running automatic teach.
// [RL4] Yellow warning for counter storage failure or teach required.
// [RL5] Blue warning when maintenance notification is due.
// [RL6] Warnings alternate with position display, never replace it permanently.
// [RL7] Colours: white, green, blue, yellow, orange, red, or off.
// [RL8] Position blink: steady, 250 ms on/off, or 125 ms on/off.
// [RL9] Fixed-colour mode: steady assigned colour, no other feedback.
// [RL10] Locate request runs locate display about 10 s, then normal display.
// [RL11] Only the highest-priority pending message is shown.
// [RL12] Locate in valve error modes: messages single-flash alternating with valve status.
// [RL13] Locate single flash 25 ms per second; white without taught position.
// [RL14] Locate: double flash upper seat lift, triple flash lower seat lift.
// [RL15] Steady valve-closed or valve-open colour while that position reported.
// [RL16] Teach success: three 100 ms flashes in valve-state colour.
// [RL17] Teach failure: three 100 ms flashes in fault colour.
// [RL18] Upper seat lift 125 ms, lower seat lift 250 ms in open colour.
// [RL19] Teach, autotune, sensor, reset, bus faults: 250 ms flashing in fault colour.
// [RL20] Internal fault: 450 ms on, 50 ms off in fault colour.
// [RL21] Service mode or manual control: 50 ms on, 450 ms off.
// [RL22] Maintenance: 1 s fault colour, then 3 s position feedback; the code shows blue, not the fault colour, for that 1 s.
// [RL23] No taught position and nothing pending: lamp off.
// [RL24] Timing from millisecond tick; reset gives lamp off, counters cleared.

module status_lamp_pattern_generator #(
  parameter integer TICK_CYCLES_P = `TICK_CYCLES
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire [2:0] lamp_mode,
  input  wire [2:0] fixed_colour,
  input  wire [2:0] error_colour,
  input  wire [2:0] closed_colour,
  input  wire [2:0] open_colour,
  input  wire [1:0] pos_blink,
  input  wire       pos_closed,
  input  wire       pos_open,
  input  wire       pos_upper_lift,
  input  wire       pos_lower_lift,
  input  wire       internal_fault,
  input  wire       bus_fault,
  input  wire       teach_fault,
  input  wire       int_sensor_invalid,
  input  wire       ext_sensor_invalid,
  input  wire       teach_reset,
  input  wire       device_reset,
  input  wire       service_mode,
  input  wire       manual_ctrl,
  input  wire       autotune_run,
  input  wire       counter_store_fail,
  input  wire       teach_required,
  input  wire       maint_due,
  input  wire       teach_ok_pulse,
  input  wire       teach_fail_pulse,
  input  wire       locate_req,
  output wire [2:0] status_lamp,
  output wire       locate_active,
  output wire       teach_flash_active
);

  // The tick divider is sized for the 1 ms count at 200 MHz
  localparam [31:0] TICK_LAST_W = TICK_CYCLES_P - 1;
  localparam [17:0] TICK_LAST   = TICK_LAST_W[17:0];

  reg [17:0] tick_cnt_reg;
  reg        ms_tick_reg;
  reg [15:0] cnt500_reg;
  reg [15:0] cnt1000_reg;
  reg [15:0] cnt4000_reg;
  reg        alt_phase_reg;
  reg [15:0] locate_ms_reg;
  reg        locate_reg;
  reg [15:0] flash_ms_reg;
  reg        flash_reg;
  reg        flash_fail_reg;
  reg [2:0]  lamp_reg;
  reg [2:0]  lamp_next;

  // Free-running millisecond tick and phase counters
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg  <= 18'h0_0000;
      ms_tick_reg   <= 1'b0;
      cnt500_reg    <= `RST_MS;
      cnt1000_reg   <= `RST_MS;
      cnt4000_reg   <= `RST_MS;
      alt_phase_reg <= 1'b0; // RL24
    end else begin
      ms_tick_reg <= (tick_cnt_reg == TICK_LAST);
      if (tick_cnt_reg == TICK_LAST) begin
        tick_cnt_reg <= 18'h0_0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 18'h0_0001; // RL24
      end
      // All phase counters share one origin, so blinks, alternation and slots stay aligned
      if (ms_tick_reg) begin
        cnt500_reg  <= (cnt500_reg == `MS_BASE_PERIOD - 16'h0001) ? `RST_MS : cnt500_reg + 16'h0001;
        cnt4000_reg <= (cnt4000_reg == `MS_MAINT_PERIOD - 16'h0001) ? `RST_MS : cnt4000_reg + 16'h0001;
        if (cnt1000_reg == `MS_ALT_HALF - 16'h0001) begin
          cnt1000_reg   <= `RST_MS;
          alt_phase_reg <= ~alt_phase_reg;
        end else begin
          cnt1000_reg <= cnt1000_reg + 16'h0001;
        end
      end
    end
  end

  // Locate window; a new request restarts it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      locate_reg    <= 1'b0;
      locate_ms_reg <= `RST_MS;
    end else if (locate_req) begin
      locate_reg    <= 1'b1;
      locate_ms_reg <= `RST_MS; // RL10
    end else if (locate_reg && ms_tick_reg) begin
      if (locate_ms_reg == `MS_LOCATE - 16'h0001) begin
        locate_reg <= 1'b0; // RL10
      end
      locate_ms_reg <= locate_ms_reg + 16'h0001;
    end
  end

  // Three-flash teach result; failure wins if both arrive together
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_reg      <= 1'b0;
      flash_fail_reg <= 1'b0;
      flash_ms_reg   <= `RST_MS;
    end else if (teach_ok_pulse || teach_fail_pulse) begin
      flash_reg      <= 1'b1;
      flash_fail_reg <= teach_fail_pulse; // RL17
      flash_ms_reg   <= `RST_MS;
    end else if (flash_reg && ms_tick_reg) begin
      if (flash_ms_reg == `MS_TEACH_TOTAL - 16'h0001) begin
        flash_reg <= 1'b0;
      end
      flash_ms_reg <= flash_ms_reg + 16'h0001;
    end
  end

  // Basic blink phases
  wire slow_on  = (cnt500_reg < `MS_SLOW_ON);
  wire fast_on  = (cnt500_reg < `MS_FAST_ON) ||
                  ((cnt500_reg >= `MS_SLOW_ON) && (cnt500_reg < `MS_FAST_OFF_END));
  wire long_on  = (cnt500_reg < `MS_LONG_ON);
  wire short_on = (cnt500_reg < `MS_SHORT);
  wire maint_on = (cnt4000_reg < `MS_MAINT_ON);
  wire pulse1   = (cnt1000_reg < `MS_PULSE);
  wire pulse2   = pulse1 || ((cnt1000_reg >= `MS_PULSE_GAP) && (cnt1000_reg < `MS_PULSE_GAP + `MS_PULSE));
  wire pulse3   = pulse2 || ((cnt1000_reg >= 16'h0002 * `MS_PULSE_GAP) &&
                             (cnt1000_reg < 16'h0002 * `MS_PULSE_GAP + `MS_PULSE));
  wire flash_on = (flash_ms_reg < `MS_TEACH_FLASH) ||
                  ((flash_ms_reg >= 16'h0002 * `MS_TEACH_FLASH) && (flash_ms_reg < 16'h0003 * `MS_TEACH_FLASH)) ||
                  ((flash_ms_reg >= 16'h0004 * `MS_TEACH_FLASH) && (flash_ms_reg < 16'h0005 * `MS_TEACH_FLASH));

  // Mode decode
  // Codes above fixed colour fall back to the valve display
  wire cat_mode  = (lamp_mode == `MODE_STATUS_CAT);
  wire show_err  = cat_mode || (lamp_mode == `MODE_VALVE_ERR) || (lamp_mode == `MODE_VALVE_ERR_WARN);
  wire show_warn = cat_mode || (lamp_mode == `MODE_VALVE_ERR_WARN);

  // Message sources
  wire err_any   = internal_fault | bus_fault | teach_fault | int_sensor_invalid |
                   ext_sensor_invalid | teach_reset | device_reset; // RL2
  wire [2:0] err_col = cat_mode ? `COL_RED : error_colour; // RL1
  wire err_on    = internal_fault ? long_on : slow_on; // RL20 RL19
  wire fc_any    = service_mode | manual_ctrl | autotune_run; // RL3
  wire fc_on     = (service_mode | manual_ctrl) ? short_on : 1'b1; // RL21
  wire oos_any   = counter_store_fail | teach_required; // RL4
  wire err_pend  = show_err && err_any;
  wire warn_pend = show_warn && (fc_any || oos_any || maint_due);

  // Highest-priority message colour and phase
  reg [2:0] msg_col;
  reg       msg_on;
  always @* begin
    msg_col = `COL_OFF;
    msg_on  = 1'b0;
    if (err_pend) begin
      msg_col = err_col;
      msg_on  = err_on; // RL11
    end else if (fc_any) begin
      msg_col = `COL_ORANGE;
      msg_on  = fc_on; // RL3
    end else if (oos_any) begin
      msg_col = `COL_YELLOW;
      msg_on  = slow_on; // RL4
    end else if (maint_due) begin
      msg_col = `COL_BLUE;
      msg_on  = 1'b1; // RL5
    end
  end

  // Position feedback colour and phase
  reg [2:0] pos_col;
  reg       pos_on;
  always @* begin
    pos_col = `COL_OFF;
    pos_on  = 1'b0; // RL23
    if (pos_upper_lift) begin
      pos_col = open_colour;
      pos_on  = fast_on; // RL18
    end else if (pos_lower_lift) begin
      pos_col = open_colour;
      pos_on  = slow_on; // RL18
    end else if (pos_closed || pos_open) begin
      pos_col = pos_closed ? closed_colour : open_colour; // RL15
      case (pos_blink)
        `BLINK_SLOW: pos_on = slow_on; // RL8
        `BLINK_FAST: pos_on = fast_on; // RL8
        default:     pos_on = 1'b1; // RL15
      endcase
    end
  end

  // Locate pulse pattern for the position
  reg [2:0] loc_col;
  reg       loc_on;
  always @* begin
    loc_col = `COL_WHITE;
    loc_on  = pulse1; // RL13
    if (pos_upper_lift) begin
      loc_col = open_colour;
      loc_on  = pulse2; // RL14
    end else if (pos_lower_lift) begin
      loc_col = open_colour;
      loc_on  = pulse3; // RL14
    end else if (pos_closed || pos_open) begin
      loc_col = pos_closed ? closed_colour : open_colour; // RL13
    end
  end

  // Final selection; setting colours pass through unchanged up to red, code 7 is turned off at the output register
  always @* begin
    lamp_next = `COL_OFF;
    if (lamp_mode == `MODE_FIXED) begin
      lamp_next = fixed_colour; // RL9 RL7
    end else if (flash_reg) begin
      if (flash_on) begin
        lamp_next = flash_fail_reg ? err_col : pos_col; // RL16 RL17
      end
    end else if (locate_reg) begin
      if (err_pend || warn_pend) begin
        if (cat_mode) begin
          lamp_next = pulse1 ? msg_col : `COL_OFF; // RL13
        end else if (alt_phase_reg) begin
          lamp_next = pulse1 ? msg_col : `COL_OFF; // RL12
        end else begin
          lamp_next = loc_on ? loc_col : `COL_OFF; // RL12
        end
      end else begin
        lamp_next = loc_on ? loc_col : `COL_OFF; // RL13 RL14
      end
    end else if (err_pend) begin
      if (cat_mode || alt_phase_reg) begin
        lamp_next = msg_on ? msg_col : `COL_OFF; // RL19 RL20
      end else begin
        lamp_next = pos_on ? pos_col : `COL_OFF;
      end
    end else if (warn_pend && !fc_any && !oos_any) begin
      // Maintenance carries its own position slot in the long off phase
      if (maint_on) begin
        lamp_next = `COL_BLUE; // RL22
      end else begin
        lamp_next = pos_on ? pos_col : `COL_OFF; // RL22
      end
    end else if (warn_pend) begin
      if (alt_phase_reg) begin
        lamp_next = msg_on ? msg_col : `COL_OFF; // RL6
      end else begin
        lamp_next = pos_on ? pos_col : `COL_OFF; // RL6
      end
    end else begin
      lamp_next = pos_on ? pos_col : `COL_OFF; // RL23
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_reg <= `RST_COLOUR; // RL24
    end else if (lamp_next > `COL_RED) begin
      // Code 7 is no colour; an unset setting darkens the lamp instead of driving a bad code
      lamp_reg <= `COL_OFF; // RL7
    end else begin
      lamp_reg <= lamp_next;
    end
  end

  assign status_lamp        = lamp_reg;
  assign locate_active      = locate_reg;
  assign teach_flash_active = flash_reg;

endmodule // status_lamp_pattern_generator

// file: sim/lamp_observer.sv
// Observer of the lamp: lengths and colour of lit and dark runs
`timescale 1ns/10ps
module lamp_observer (
  input  wire       core_clk,
  input  wire [2:0] status_lamp,
  output int        on_len,
  output int        off_len,
  output logic [2:0] on_col,
  output int        rises
);
  int         run = 0;
  logic [2:0] prev = 3'h0;
  initial begin
    on_len = 0;
    off_len = 0;
    on_col = 3'h0;
    rises = 0;
  end
  // Colour changes inside a lit run do not split it, like the eye
  always @(posedge core_clk) begin
    if ((status_lamp != 3'h0) != (prev != 3'h0)) begin
      if (prev != 3'h0) begin
        on_len <= run;
        on_col <= prev;
      end else begin
        off_len <= run;
        rises <= rises + 1;
      end
      run <= 1;
    end else run <= run + 1;
    prev <= status_lamp;
  end
endmodule // lamp_observer

// file: sim/status_lamp_checker_sva.sv
// Port assertions for the status lamp pattern generator
`timescale 1ns/10ps
`include "status_lamp_defs.vh"
module status_lamp_checker #(
  parameter integer TICK_CYCLES_P = 4
) (
  input wire       core_clk,
  input wire       rst_n,
  input wire [2:0] lamp_mode,
  input wire [2:0] fixed_colour,
  input wire [2:0] closed_colour,
  input wire [1:0] pos_blink,
  input wire       pos_closed,
  input wire       pos_open,
  input wire       pos_upper_lift,
  input wire       pos_lower_lift,
  input wire       internal_fault,
  input wire       bus_fault,
  input wire       teach_ok_pulse,
  input wire       teach_fail_pulse,
  input wire       locate_req,
  input wire [2:0] status_lamp,
  input wire       locate_active,
  input wire       teach_flash_active
);
  localparam int LOC_MIN = 9999 * TICK_CYCLES_P + 1;
  localparam int LOC_MAX = 10000 * TICK_CYCLES_P;
  logic [31:0] loc_cnt_reg;
  // Cycles since the last locate request
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) loc_cnt_reg <= 32'h0000_0000;
    else if (locate_req) loc_cnt_reg <= 32'h0000_0000;
    else loc_cnt_reg <= loc_cnt_reg + 32'h0000_0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // First edge after release is skipped, the lamp may still hold its reset value
  sequence quiet_s;
    $past(rst_n) && !teach_flash_active && !locate_active && !locate_req && !teach_ok_pulse && !teach_fail_pulse;
  endsequence
  sequence teach_req_s; teach_ok_pulse || teach_fail_pulse; endsequence
  reset_idle_a: assert property ($rose(rst_n) |-> status_lamp == 3'h0 && !locate_active && !teach_flash_active)
    else $error("lamp not idle after reset");
  legal_colour_a: assert property (status_lamp <= `COL_RED)
    else $error("lamp code out of range");
  fixed_hold_a: assert property ($past(rst_n) && lamp_mode == `MODE_FIXED |=> status_lamp == $past(fixed_colour))
    else $error("fixed colour not shown");
  locate_start_a: assert property (locate_req |=> locate_active [*8])
    else $error("locate window did not open");
  locate_len_a: assert property ($fell(locate_active) |-> loc_cnt_reg >= LOC_MIN && loc_cnt_reg <= LOC_MAX)
    else $error("locate window length wrong");
  teach_start_a: assert property (teach_req_s |=> teach_flash_active [*8])
    else $error("teach flash did not start");
  cat_error_a: assert property (quiet_s ##0 (lamp_mode == `MODE_STATUS_CAT && (internal_fault || bus_fault))
    |=> status_lamp inside {`COL_OFF, `COL_RED})
    else $error("status category error not red");
  closed_steady_a: assert property (quiet_s ##0 (lamp_mode == `MODE_VALVE && pos_closed && !pos_upper_lift
    && !pos_lower_lift && pos_blink == `BLINK_STEADY) |=> status_lamp == $past(closed_colour))
    else $error("closed colour not steady");
  between_off_a: assert property (quiet_s ##0 (lamp_mode == `MODE_VALVE && !pos_closed && !pos_open
    && !pos_upper_lift && !pos_lower_lift) |=> status_lamp == `COL_OFF)
    else $error("lamp lit between positions");
endmodule // status_lamp_checker

bind status_lamp_pattern_generator status_lamp_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .lamp_mode(lamp_mode), .fixed_colour(fixed_colour),
  .closed_colour(closed_colour), .pos_blink(pos_blink), .pos_closed(pos_closed), .pos_open(pos_open),
  .pos_upper_lift(pos_upper_lift), .pos_lower_lift(pos_lower_lift), .internal_fault(internal_fault),
  .bus_fault(bus_fault), .teach_ok_pulse(teach_ok_pulse), .teach_fail_pulse(teach_fail_pulse),
  .locate_req(locate_req), .status_lamp(status_lamp), .locate_active(locate_active),
  .teach_flash_active(teach_flash_active));

// file: sim/status_lamp_pattern_generator_tb.sv
// Self-checking bench for the status lamp pattern generator
`timescale 1ns/10ps
`include "status_lamp_defs.vh"
module status_lamp_pattern_generator_tb;
  localparam int T = 2;
  logic core_clk = 1'b0, rst_n = 1'b0, teach_ok_pulse = 1'b0, teach_fail_pulse = 1'b0, locate_req = 1'b0;
  logic [2:0] lamp_mode = 3'h0, fixed_colour = 3'h0, error_colour = 3'h6, closed_colour = 3'h2, open_colour = 3'h4;
  logic [1:0] pos_blink = 2'h0;
  logic [3:0] pos = 4'h0;
  logic [12:0] flags = 13'h0000;
  logic [31:0] seed = 32'hcb9c_1f28;
  wire [2:0] status_lamp, on_col;
  wire locate_active, teach_flash_active;
  int on_len, off_len, rises, n_mismatch = 0, compares = 0, cyc = 0, i, r0, t0, na, nb;
  logic [2:0] c;
  status_lamp_pattern_generator #(.TICK_CYCLES_P(T)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .lamp_mode(lamp_mode), .fixed_colour(fixed_colour),
    .error_colour(error_colour), .closed_colour(closed_colour), .open_colour(open_colour), .pos_blink(pos_blink),
    .pos_closed(pos[0]), .pos_open(pos[1]), .pos_upper_lift(pos[2]), .pos_lower_lift(pos[3]),
    .internal_fault(flags[0]), .bus_fault(flags[1]), .teach_fault(flags[2]), .int_sensor_invalid(flags[3]),
    .ext_sensor_invalid(flags[4]), .teach_reset(flags[5]), .device_reset(flags[6]), .service_mode(flags[7]),
    .manual_ctrl(flags[8]), .autotune_run(flags[9]), .counter_store_fail(flags[10]), .teach_required(flags[11]),
    .maint_due(flags[12]), .teach_ok_pulse(teach_ok_pulse), .teach_fail_pulse(teach_fail_pulse),
    .locate_req(locate_req), .status_lamp(status_lamp), .locate_active(locate_active),
    .teach_flash_active(teach_flash_active));
  lamp_observer i_eye (.core_clk(core_clk), .status_lamp(status_lamp), .on_len(on_len), .off_len(off_len),
    .on_col(on_col), .rises(rises));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  function automatic int ms(int m); return m * T; endfunction
  function logic [31:0] xs(); seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; return seed; endfunction
  function logic [2:0] rcol(); return 3'(xs() % 6 + 1); endfunction
  task wait_ms(int m); repeat (ms(m)) @(posedge core_clk); endtask
  task check_col(logic [2:0] got, logic [2:0] exp);
    compares++;
    if (got !== exp) begin n_mismatch++; $display("unexpected colour at %0t: got %h exp %h", $time, got, exp); end
  endtask
  // One ms of slack: a phase may start on the next tick
  task check_len(int got, int exp);
    compares++;
    if (got < exp - T || got > exp + T) begin
      n_mismatch++;
      $display("unexpected length at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task check_cnt(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin n_mismatch++; $display("unexpected count at %0t: got %h exp %h", $time, got, exp); end
  endtask
  task show(logic [3:0] p, logic [1:0] b, logic [12:0] f, logic [2:0] m, int w);
    @(posedge core_clk); pos <= p; pos_blink <= b; flags <= f; lamp_mode <= m; wait_ms(w);
  endtask
  task teach(logic fail, logic [2:0] col, int n);
    r0 = rises;
    @(posedge core_clk); teach_ok_pulse <= !fail; teach_fail_pulse <= fail;
    @(posedge core_clk); teach_ok_pulse <= 1'b0; teach_fail_pulse <= 1'b0;
    wait_ms(550);
    for (i = 0; i < ms(100) && teach_flash_active === 1'b1; i++) @(posedge core_clk);
    check_cnt(rises - r0, n); check_len(off_len, ms(100)); check_col(on_col, col); check_cnt(i < ms(100), 1);
  endtask
  task locate_seen(logic [3:0] p, int n, logic [2:0] col);
    @(posedge core_clk); pos <= p; repeat (10) @(posedge core_clk);
    r0 = rises; wait_ms(1000);
    check_cnt(rises - r0, n); check_len(on_len, ms(25)); check_col(on_col, col);
  endtask
  // Counts cycles of two colours over one whole 2 s alternation period
  task split(logic [3:0] p, logic [12:0] f, logic [2:0] m, logic [2:0] ca, int ma, logic [2:0] cb, int mb);
    show(p, `BLINK_STEADY, f, m, 10);
    na = 0;
    nb = 0;
    repeat (ms(2000)) begin
      @(posedge core_clk);
      na += int'(status_lamp === ca);
      nb += int'(status_lamp === cb);
    end
    check_len(na, ms(ma));
    check_len(nb, ms(mb));
  endtask
  task tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (ms(40000)) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    check_col(status_lamp, `COL_OFF); check_cnt(locate_active + teach_flash_active, 0);
    rst_n <= 1'b1;
    open_colour <= rcol();
    error_colour <= rcol();
    // Valve mode ignores every message, so random flags must never disturb the closed colour
    for (int k = 0; k < 100; k++) begin
      @(posedge core_clk); c = rcol(); closed_colour <= c; flags <= 13'(xs()); pos <= 4'h1;
      @(posedge core_clk); #1 check_col(status_lamp, c);
    end
    show(4'h1, `BLINK_SLOW, 13'h0, `MODE_VALVE, 1000);
    check_len(on_len, ms(250)); check_len(off_len, ms(250)); check_col(on_col, closed_colour);
    show(4'h1, `BLINK_FAST, 13'h0, `MODE_VALVE, 500);
    check_len(on_len, ms(125)); check_len(off_len, ms(125));
    show(4'h4, `BLINK_STEADY, 13'h0, `MODE_VALVE, 300);
    check_len(on_len, ms(125)); check_col(on_col, open_colour);
    show(4'h8, `BLINK_STEADY, 13'h0, `MODE_VALVE, 600);
    check_len(on_len, ms(250)); check_col(on_col, open_colour);
    show(4'h0, `BLINK_STEADY, 13'h0001, `MODE_STATUS_CAT, 1000);
    check_len(on_len, ms(450)); check_len(off_len, ms(50)); check_col(on_col, `COL_RED);
    show(4'h0, `BLINK_STEADY, 13'h0002, `MODE_STATUS_CAT, 600);
    check_len(on_len, ms(250)); check_col(on_col, `COL_RED);
    show(4'h0, `BLINK_STEADY, 13'h0080, `MODE_STATUS_CAT, 2200);
    check_len(on_len, ms(50)); check_col(on_col, `COL_ORANGE);
    show(4'h0, `BLINK_STEADY, 13'h1000, `MODE_STATUS_CAT, 5000);
    check_len(on_len, ms(1000)); check_col(on_col, `COL_BLUE);
    @(posedge core_clk);
    error_colour <= `COL_RED;
    closed_colour <= `COL_GREEN;
    // Warnings are refused in the error-only mode, so only the error alternates with the position
    split(4'h1, 13'h0404, `MODE_VALVE_ERR, `COL_GREEN, 1000, `COL_RED, 500);
    split(4'h1, 13'h0400, `MODE_VALVE_ERR_WARN, `COL_GREEN, 1000, `COL_YELLOW, 500);
    split(4'h1, 13'h1600, `MODE_VALVE_ERR_WARN, `COL_GREEN, 1000, `COL_ORANGE, 1000);
    show(4'h0, `BLINK_STEADY, 13'h0, `MODE_VALVE, 10);
    teach(1'b1, error_colour, 3);
    show(4'h1, `BLINK_STEADY, 13'h0, `MODE_VALVE, 10);
    teach(1'b0, closed_colour, 2);
    @(posedge core_clk); locate_req <= 1'b1;
    @(posedge core_clk); locate_req <= 1'b0; t0 = cyc;
    locate_seen(4'h0, 1, `COL_WHITE);
    locate_seen(4'h4, 2, open_colour);
    locate_seen(4'h8, 3, open_colour);
    split(4'h0, 13'h0004, `MODE_VALVE_ERR, `COL_WHITE, 25, `COL_RED, 25);
    for (i = 0; i < ms(8000) && locate_active === 1'b1; i++) @(posedge core_clk);
    check_len(cyc - t0, ms(10000));
    @(posedge core_clk); c = rcol(); fixed_colour <= c; lamp_mode <= `MODE_FIXED; flags <= 13'h0001;
    repeat (3) @(posedge core_clk);
    #1 check_col(status_lamp, c);
    tally_and_finish;
  end
endmodule // status_lamp_pattern_generator_tb
